// ===== logic/vtd_video_timing.v
// Raster timing, skew, pin selection and DMA burst logic of the display controller
// Overview of operation
// - Register selected from six address lines only while chip select is active.
// - Fourteen-bit registers are two byte registers, low byte first.
// - Only vertical cursor is readable, at a separate read address; timing write-only.
// - Line total register sets full line length in character times; at least 12.
// - Visible-characters register holds N-1 for N visible characters per line.
// - Visible line window starts N character times after horizontal sync start.
// - Horizontal sync starts at line end and lasts sync-width character times.
// - Vertical sync lasts vsync-width lines, independent of active display.
// - First visible line follows vertical sync start by N lines for value N+1.
// - Visible rows register holds N-1 for N displayed data rows.
// - Low five row-height bits are lines per row minus one; serial above 16.
// - Frame line count is eleven bits: three high row-height bits plus low byte.
// - Two top pin/skew bits pick pin functions by buffer mode.
// - Cursor delayed from visible window by 0 to 5 character clocks.
// - Horizontal blank delayed 0 to 5 clocks; zero skew matches window edges.
// - DMA disable drops request and floats bus; restart needs start command.
// - Wait 4(N+1) character clocks between bursts; code 111 means none.
// - Each burst performs 4(N+1) DMA cycles before bus release, except with delay code 111.
// - Delay code 111 fetches a whole row of characters in one burst.
// - Mode control is double-buffered and takes effect during vertical retrace.
`timescale 1ns/10ps
`include "vtd_consts.vh"
module vtd_video_timing #(
   parameter AW = 6,
   parameter DW = 8
) (
   input wire sys_clk,
   input wire rst_b,
   input wire character_clock,
   input wire cs_b,
   input wire wr_b,
   input wire rd_b,
   input wire [AW-1:0] register_address_lines,
   input wire [DW-1:0] host_wdata,
   output reg [DW-1:0] host_rdata,
   output reg host_rdata_oe,
   input wire dma_ack,
   input wire light_pen_strobe_in,
   input wire [7:0] cursor_col,
   output reg dma_request_out,
   output reg [13:0] display_memory_address_bus,
   output reg display_memory_address_oe,
   output reg fetch_valid,
   output reg [13:0] fetch_addr,
   input wire fetch_ready,
   output reg visible_line_window,
   output reg composite_blank_out,
   output reg cursor_out,
   output reg composite_sync_out,
   output reg hsync_out,
   output reg vsync_out,
   output reg [3:0] parallel_line_count,
   output reg serial_line_count_gate,
   output reg serial_line_count_data,
   output reg tristate_control_out,
   output reg row_buffer_write_enable,
   output reg [1:0] pin_function_sel,
   output reg pen_latched
);
   // Synchronisers for pin inputs
   reg [1:0] character_clock_s, cs_s, wr_s, rd_s, ack_s, pen_s;
   reg character_clock_d, wr_d;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         character_clock_s <= 2'h0;
         cs_s <= 2'h3;
         wr_s <= 2'h3;
         rd_s <= 2'h3;
         ack_s <= 2'h0;
         pen_s <= 2'h0;
         character_clock_d <= 1'b0;
         wr_d <= 1'b0;
      end else begin
         character_clock_s <= {character_clock_s[0], character_clock};
         cs_s <= {cs_s[0], cs_b};
         wr_s <= {wr_s[0], wr_b};
         rd_s <= {rd_s[0], rd_b};
         ack_s <= {ack_s[0], dma_ack};
         pen_s <= {pen_s[0], light_pen_strobe_in};
         character_clock_d <= character_clock_s[1];
         wr_d <= !wr_s[1] && !cs_s[1];
      end
   end
   wire cce = character_clock_s[1] && !character_clock_d;
   wire sel = !cs_s[1];
   wire wr_stb = sel && !wr_s[1] && !wr_d;
   // Host registers
   reg [7:0] line_total_chars, visible_chars_per_row, hsync_delay, hsync_width;
   reg [7:0] vsync_width, vsync_delay, visible_rows_per_frame;
   reg [7:0] row_height_and_frame_lines_high, frame_lines_low;
   reg [7:0] pin_select_and_skew, dma_burst_control, mode_shadow, mode_live;
   reg [7:0] vcurs_lo, vcurs_hi;
   reg start_pend, dma_run;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         line_total_chars <= `VTD_RESET_BYTE;
         visible_chars_per_row <= `VTD_RESET_BYTE;
         hsync_delay <= `VTD_RESET_BYTE;
         hsync_width <= `VTD_RESET_BYTE;
         vsync_width <= `VTD_RESET_BYTE;
         vsync_delay <= `VTD_RESET_BYTE;
         visible_rows_per_frame <= `VTD_RESET_BYTE;
         row_height_and_frame_lines_high <= `VTD_RESET_BYTE;
         frame_lines_low <= `VTD_RESET_BYTE;
         pin_select_and_skew <= `VTD_RESET_BYTE;
         dma_burst_control <= 8'h80;
         mode_shadow <= `VTD_RESET_BYTE;
         vcurs_lo <= `VTD_RESET_BYTE;
         vcurs_hi <= `VTD_RESET_BYTE;
         start_pend <= 1'b0;
      end else if (wr_stb) begin
         if (register_address_lines == `VTD_ADDR_LINE_TOTAL) begin
            line_total_chars <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_VIS_CHARS) begin
            visible_chars_per_row <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_HS_DELAY) begin
            hsync_delay <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_HS_WIDTH) begin
            hsync_width <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_VS_WIDTH) begin
            vsync_width <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_VS_DELAY) begin
            vsync_delay <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_PIN_SKEW) begin
            pin_select_and_skew <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_VIS_ROWS) begin
            visible_rows_per_frame <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_ROW_HEIGHT) begin
            row_height_and_frame_lines_high <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_FRAME_LO) begin
            frame_lines_low <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_DMA_CTRL) begin
            dma_burst_control <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_MODE_CTRL) begin
            mode_shadow <= {1'b0, host_wdata[6:0]};
         end else if (register_address_lines == `VTD_ADDR_START_CMD) begin
            start_pend <= 1'b1;
         end else if (register_address_lines == `VTD_ADDR_VCURS_WR) begin
            vcurs_lo <= host_wdata;
         end else if (register_address_lines == `VTD_ADDR_VCURS_WR + 6'h01) begin
            vcurs_hi <= host_wdata;
         end
      end else if (dma_run) begin
         start_pend <= 1'b0;
      end
   end
   // Read path: only the vertical cursor reads back
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         host_rdata <= 8'h00;
         host_rdata_oe <= 1'b0;
      end else begin
         host_rdata_oe <= sel && !rd_s[1];
         if (register_address_lines == `VTD_ADDR_VCURS_RD) begin
            host_rdata <= vcurs_lo;
         end else if (register_address_lines == `VTD_ADDR_VCURS_RD + 6'h01) begin
            host_rdata <= vcurs_hi;
         end else begin
            host_rdata <= 8'h00;
         end
      end
   end
   // Raster counters
   reg [7:0] hcnt, vsw_cnt, hsw_cnt, vdly_cnt;
   reg [10:0] lcnt;
   reg [4:0] scan;
   reg [7:0] row;
   reg hs, vs, vwait, vact;
   wire [10:0] frame_lines = {row_height_and_frame_lines_high[7:5], frame_lines_low};
   wire line_end = cce && (hcnt >= line_total_chars - 8'h01);
   wire h_vis = vact && (hcnt >= hsync_delay) &&
      (hcnt <= hsync_delay + visible_chars_per_row);
   wire row_end = (scan == row_height_and_frame_lines_high[4:0]);
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hcnt <= 8'h00;
         lcnt <= 11'h000;
         scan <= 5'h00;
         row <= 8'h00;
         hs <= 1'b0;
         hsw_cnt <= 8'h00;
         vs <= 1'b0;
         vsw_cnt <= 8'h00;
         vwait <= 1'b0;
         vdly_cnt <= 8'h00;
         vact <= 1'b0;
         mode_live <= 8'h00;
      end else if (cce) begin
         hcnt <= line_end ? 8'h00 : hcnt + 8'h01;
         if (line_end) begin
            hs <= 1'b1;
            hsw_cnt <= hsync_width;
         end else if (hsw_cnt <= 8'h01) begin
            hs <= 1'b0;
         end else begin
            hsw_cnt <= hsw_cnt - 8'h01;
         end
         if (line_end) begin
            lcnt <= (lcnt >= frame_lines - 11'h001) ? 11'h000 : lcnt + 11'h001;
            if (lcnt >= frame_lines - 11'h001) begin
               vs <= 1'b1;
               vsw_cnt <= vsync_width;
               vwait <= 1'b1;
               vdly_cnt <= vsync_delay;
               vact <= 1'b0;
               mode_live <= mode_shadow;
            end else begin
               if (vsw_cnt <= 8'h01) begin
                  vs <= 1'b0;
               end else begin
                  vsw_cnt <= vsw_cnt - 8'h01;
               end
               if (vwait) begin
                  if (vdly_cnt <= 8'h02) begin
                     vwait <= 1'b0;
                     vact <= 1'b1;
                     scan <= 5'h00;
                     row <= 8'h00;
                  end else begin
                     vdly_cnt <= vdly_cnt - 8'h01;
                  end
               end else if (vact) begin
                  scan <= row_end ? 5'h00 : scan + 5'h01;
                  if (row_end) begin
                     row <= row + 8'h01;
                     if (row == visible_rows_per_frame) begin
                        vact <= 1'b0;
                     end
                  end
               end
            end
         end
      end
   end
   // Skew pipelines for cursor and blank
   reg [5:0] vis_pipe, cursor_out_pipe;
   wire [2:0] cskew = pin_select_and_skew[`VTD_CSKEW_MSB:`VTD_CSKEW_LSB];
   wire [2:0] bskew = pin_select_and_skew[`VTD_BSKEW_MSB:`VTD_BSKEW_LSB];
   wire cursor_out_raw = h_vis && (hcnt - hsync_delay == cursor_col) &&
      (row == vcurs_lo);
   wire [2:0] cs_sel = (cskew > `VTD_SKEW_MAX) ? `VTD_SKEW_MAX : cskew;
   wire [2:0] bs_sel = (bskew > `VTD_SKEW_MAX) ? `VTD_SKEW_MAX : bskew;
   wire [2:0] mode_op = mode_live[3:1];
   wire drb = (mode_op == `VTD_MODE_DRB) || (mode_op == `VTD_MODE_ATTR);
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         vis_pipe <= 6'h00;
         cursor_out_pipe <= 6'h00;
         visible_line_window <= 1'b0;
         composite_blank_out <= 1'b1;
         cursor_out <= 1'b0;
         composite_sync_out <= 1'b0;
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
         parallel_line_count <= 4'h0;
         serial_line_count_gate <= 1'b0;
         serial_line_count_data <= 1'b0;
         tristate_control_out <= 1'b0;
         pin_function_sel <= 2'h0;
         pen_latched <= 1'b0;
      end else begin
         if (cce) begin
            vis_pipe <= {vis_pipe[4:0], h_vis};
            cursor_out_pipe <= {cursor_out_pipe[4:0], cursor_out_raw};
         end
         visible_line_window <= h_vis;
         cursor_out <= (cs_sel == 3'h0) ? cursor_out_raw : cursor_out_pipe[cs_sel - 3'h1];
         composite_blank_out <= !((bs_sel == 3'h0) ? h_vis : vis_pipe[bs_sel - 3'h1]);
         hsync_out <= hs;
         vsync_out <= vs;
         composite_sync_out <= hs ^ vs;
         pin_function_sel <= {drb, 1'b0} | pin_select_and_skew[`VTD_PIN_MSB:`VTD_PIN_LSB];
         parallel_line_count <= scan[3:0];
         serial_line_count_gate <= (hcnt < 8'h05) && vact;
         serial_line_count_data <= (hcnt < 8'h05) && scan[hcnt[2:0]];
         tristate_control_out <= !drb && h_vis;
         if (pen_s[1]) begin
            pen_latched <= 1'b1;
         end
      end
   end
   // DMA burst engine with two-entry output buffer
   localparam D_IDLE = 2'h0;
   localparam D_REQ = 2'h1;
   localparam D_BURST = 2'h2;
   localparam D_WAIT = 2'h3;
   reg [1:0] dstate;
   reg [7:0] burst_left, wait_cnt;
   reg [13:0] dma_addr;
   reg [13:0] buf0, buf1;
   reg [1:0] bcnt;
   wire dma_dis = dma_burst_control[`VTD_DMA_DIS_BIT];
   wire [2:0] bdly = dma_burst_control[`VTD_BDLY_MSB:`VTD_BDLY_LSB];
   wire [3:0] bcount = dma_burst_control[`VTD_BCNT_MSB:`VTD_BCNT_LSB];
   wire buf_ready = (bcnt != 2'h2);
   wire pop = fetch_valid && fetch_ready;
   wire push = (dstate == D_BURST) && cce && buf_ready && !dma_dis;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dstate <= D_IDLE;
         burst_left <= 8'h00;
         wait_cnt <= 8'h00;
         dma_addr <= 14'h0000;
         dma_run <= 1'b0;
         dma_request_out <= 1'b0;
         display_memory_address_bus <= 14'h0000;
         display_memory_address_oe <= 1'b0;
         row_buffer_write_enable <= 1'b0;
      end else if (dma_dis) begin
         dstate <= D_IDLE;
         dma_run <= 1'b0;
         dma_request_out <= 1'b0;
         display_memory_address_oe <= 1'b0;
         row_buffer_write_enable <= 1'b0;
      end else begin
         row_buffer_write_enable <= push;
         if (start_pend) begin
            dma_run <= 1'b1;
         end
         case (dstate)
            D_IDLE: begin
               if (dma_run && !ack_s[1]) begin
                  dma_request_out <= 1'b1;
                  dstate <= D_REQ;
               end
            end
            D_REQ: begin
               if (ack_s[1]) begin
                  dma_request_out <= 1'b0;
                  display_memory_address_oe <= 1'b1;
                  burst_left <= (bdly == `VTD_BDLY_NONE) ?
                     visible_chars_per_row + 8'h01 : {2'h0, bcount, 2'h0} + 8'h04;
                  dstate <= D_BURST;
               end
            end
            D_BURST: begin
               if (push) begin
                  display_memory_address_bus <= dma_addr;
                  dma_addr <= dma_addr + 14'h0001;
                  burst_left <= burst_left - 8'h01;
                  if (burst_left == 8'h01) begin
                     display_memory_address_oe <= 1'b0;
                     wait_cnt <= {3'h0, bdly, 2'h0} + 8'h04;
                     dstate <= (bdly == `VTD_BDLY_NONE) ? D_IDLE : D_WAIT;
                  end
               end
            end
            D_WAIT: begin
               if (cce) begin
                  if (wait_cnt <= 8'h01) begin
                     dstate <= D_IDLE;
                  end else begin
                     wait_cnt <= wait_cnt - 8'h01;
                  end
               end
            end
            default: dstate <= D_IDLE;
         endcase
      end
   end
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bcnt <= 2'h0;
         buf0 <= 14'h0000;
         buf1 <= 14'h0000;
         fetch_valid <= 1'b0;
         fetch_addr <= 14'h0000;
      end else begin
         if (push && !pop) begin
            bcnt <= bcnt + 2'h1;
         end else if (pop && !push) begin
            bcnt <= bcnt - 2'h1;
         end
         if (push) begin
            if ((bcnt == 2'h0) || (bcnt == 2'h1 && pop)) begin
               buf0 <= dma_addr;
            end else begin
               buf1 <= dma_addr;
            end
         end
         if (pop && bcnt == 2'h2) begin
            buf0 <= buf1;
         end
         fetch_valid <= (bcnt != 2'h0) && !(pop && bcnt == 2'h1 && !push);
         fetch_addr <= (pop || !fetch_valid) ? ((bcnt == 2'h2 || (pop && bcnt != 2'h1)) ?
            buf1 : (pop && push) ? dma_addr : buf0) : fetch_addr;
      end
   end
endmodule // vtd_video_timing

// ===== inc/vtd_consts.vh
// Register addresses, field positions and timing constants for the raster timing block
`ifndef VTD_CONSTS_VH
`define VTD_CONSTS_VH
`define VTD_ADDR_LINE_TOTAL 6'h00
`define VTD_ADDR_VIS_CHARS 6'h01
`define VTD_ADDR_HS_DELAY 6'h02
`define VTD_ADDR_HS_WIDTH 6'h03
`define VTD_ADDR_VS_WIDTH 6'h04
`define VTD_ADDR_VS_DELAY 6'h05
`define VTD_ADDR_PIN_SKEW 6'h06
`define VTD_ADDR_VIS_ROWS 6'h07
`define VTD_ADDR_ROW_HEIGHT 6'h08
`define VTD_ADDR_FRAME_LO 6'h09
`define VTD_ADDR_DMA_CTRL 6'h0a
`define VTD_ADDR_MODE_CTRL 6'h0b
`define VTD_ADDR_START_CMD 6'h15
`define VTD_ADDR_VCURS_WR 6'h18
`define VTD_ADDR_VCURS_RD 6'h38
`define VTD_DMA_DIS_BIT 7
`define VTD_BDLY_MSB 6
`define VTD_BDLY_LSB 4
`define VTD_BCNT_MSB 3
`define VTD_BCNT_LSB 0
`define VTD_PIN_MSB 7
`define VTD_PIN_LSB 6
`define VTD_CSKEW_MSB 5
`define VTD_CSKEW_LSB 3
`define VTD_BSKEW_MSB 2
`define VTD_BSKEW_LSB 0
`define VTD_BDLY_NONE 3'h7
`define VTD_SKEW_MAX 3'h5
`define VTD_MODE_DRB 3'h1
`define VTD_MODE_ATTR 3'h7
`define VTD_RESET_BYTE 8'h00
`endif

// ===== verification/vtd_dma_partner.sv
// DMA acknowledge and fetch sink model facing the timing block
`timescale 1ns/10ps
module vtd_dma_partner #(
   parameter ACK_LAG = 3
) (
   input wire sys_clk,
   input wire rst_b,
   input wire dma_request_out,
   input wire display_memory_address_oe,
   input wire fetch_valid,
   input wire stall,
   output reg dma_ack,
   output reg fetch_ready,
   output reg [31:0] words_at_ack
);
   reg [31:0] words;
   reg [3:0] lag;
   reg seen_oe;
   reg [1:0] ph;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dma_ack <= 1'b0;
         fetch_ready <= 1'b0;
         words_at_ack <= 32'h0;
         words <= 32'h0;
         lag <= 4'h0;
         seen_oe <= 1'b0;
         ph <= 2'h0;
      end else begin
         ph <= ph + 2'h1;
         fetch_ready <= !stall || ph[1];
         if (fetch_valid && fetch_ready) words <= words + 32'h1;
         lag <= (dma_request_out && !dma_ack) ? lag + 4'h1 : 4'h0;
         if (!dma_ack && dma_request_out && lag == ACK_LAG) begin
            dma_ack <= 1'b1;
            words_at_ack <= words;
            seen_oe <= 1'b0;
         end else if (dma_ack && display_memory_address_oe) seen_oe <= 1'b1;
         else if (dma_ack && seen_oe) dma_ack <= 1'b0;
      end
   end
endmodule // vtd_dma_partner

// ===== verification/vtd_timing_assertions.sv
// Checker on host reads, DMA handshake and fetch buffer of the timing block
`timescale 1ns/10ps
`include "vtd_consts.vh"
module vtd_timing_assertions #(
   parameter AW = 6,
   parameter DW = 8
) (
   input wire sys_clk,
   input wire rst_b,
   input wire cs_b,
   input wire wr_b,
   input wire rd_b,
   input wire [AW-1:0] register_address_lines,
   input wire [DW-1:0] host_wdata,
   input wire [DW-1:0] host_rdata,
   input wire host_rdata_oe,
   input wire dma_ack,
   input wire dma_request_out,
   input wire display_memory_address_oe,
   input wire fetch_valid,
   input wire [13:0] fetch_addr,
   input wire fetch_ready,
   input wire [1:0] pin_function_sel,
   input wire pen_latched
);
   reg dis;
   reg [1:0] pins;
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dis <= 1'b1;
         pins <= 2'h0;
      end else if (!cs_b && !wr_b) begin
         if (register_address_lines == `VTD_ADDR_DMA_CTRL) dis <= host_wdata[7];
         if (register_address_lines == `VTD_ADDR_PIN_SKEW) pins <= host_wdata[7:6];
      end
   end
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_read; (!cs_b && !rd_b)[*6]; endsequence
   sequence s_idle_host; cs_b[*8]; endsequence
   sequence s_plain_read; (!cs_b && !rd_b && register_address_lines != 6'h38
      && register_address_lines != 6'h39)[*6]; endsequence
   property p_rd_drive; s_read |-> host_rdata_oe; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
   property p_rd_quiet; s_idle_host |-> !host_rdata_oe; endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read driven unselected");
   property p_rd_zero; s_plain_read |-> host_rdata == {DW{1'b0}}; endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("write-only place read back");
   property p_dis_idle; (dis && cs_b)[*8] |-> !dma_request_out && !display_memory_address_oe;
   endproperty
   a_dis_idle: assert property (p_dis_idle) else $error("DMA active while disabled");
   property p_req_hold; (dma_request_out && !dma_ack && !dis && cs_b)[*4] |=> dma_request_out;
   endproperty
   a_req_hold: assert property (p_req_hold) else $error("request dropped unanswered");
   property p_fetch_hold; fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_addr);
   endproperty
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch word lost");
   property p_pin_sel; s_idle_host |-> pin_function_sel == pins; endproperty
   a_pin_sel: assert property (p_pin_sel) else $error("pin function mismatch");
   property p_pen_sticky; pen_latched |=> pen_latched; endproperty
   a_pen_sticky: assert property (p_pen_sticky) else $error("pen latch cleared");
endmodule // vtd_timing_assertions
bind vtd_video_timing vtd_timing_assertions #(.AW(AW), .DW(DW)) u_chk (.sys_clk(sys_clk),
   .rst_b(rst_b), .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b), .host_wdata(host_wdata),
   .register_address_lines(register_address_lines), .host_rdata(host_rdata),
   .host_rdata_oe(host_rdata_oe), .dma_ack(dma_ack), .dma_request_out(dma_request_out),
   .display_memory_address_oe(display_memory_address_oe), .fetch_valid(fetch_valid),
   .fetch_addr(fetch_addr), .fetch_ready(fetch_ready), .pin_function_sel(pin_function_sel),
   .pen_latched(pen_latched));

// ===== verification/vtd_video_timing_test.sv
// Self-checking bench of the raster timing block
`timescale 1ns/10ps
`include "vtd_consts.vh"
module vtd_video_timing_test;
   reg sys_clk, rst_b, character_clock, cs_b, wr_b, rd_b, light_pen_strobe_in, stall;
   reg [5:0] register_address_lines;
   reg [7:0] host_wdata;
   wire [7:0] host_rdata;
   wire [1:0] pin_function_sel;
   wire [31:0] words_at_ack;
   wire host_rdata_oe, dma_ack, dma_request_out, display_memory_address_oe, fetch_valid;
   wire fetch_ready, visible_line_window, composite_blank_out, hsync_out, vsync_out, pen_latched;
   wire cursor_out;
   wire [7:0] mon = {cursor_out, dma_ack, display_memory_address_oe, dma_request_out,
      composite_blank_out, visible_line_window, vsync_out, hsync_out};
   integer bad_count, samples_checked, cyc = 0, ta, tb, tc;
   vtd_video_timing uut (.sys_clk(sys_clk), .rst_b(rst_b), .character_clock(character_clock),
      .cs_b(cs_b), .wr_b(wr_b), .rd_b(rd_b), .register_address_lines(register_address_lines),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
      .dma_ack(dma_ack), .light_pen_strobe_in(light_pen_strobe_in), .cursor_col(8'h03),
      .dma_request_out(dma_request_out), .display_memory_address_bus(),
      .display_memory_address_oe(display_memory_address_oe), .fetch_valid(fetch_valid),
      .fetch_addr(), .fetch_ready(fetch_ready), .visible_line_window(visible_line_window),
      .composite_blank_out(composite_blank_out), .cursor_out(cursor_out), .composite_sync_out(),
      .hsync_out(hsync_out), .vsync_out(vsync_out), .parallel_line_count(),
      .serial_line_count_gate(), .serial_line_count_data(), .tristate_control_out(),
      .row_buffer_write_enable(), .pin_function_sel(pin_function_sel), .pen_latched(pen_latched));
   vtd_dma_partner u_dma (.sys_clk(sys_clk), .rst_b(rst_b), .dma_request_out(dma_request_out),
      .display_memory_address_oe(display_memory_address_oe), .fetch_valid(fetch_valid),
      .stall(stall), .dma_ack(dma_ack), .fetch_ready(fetch_ready), .words_at_ack(words_at_ack));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      character_clock <= #1 cyc[1];
   end
   task check(input [31:0] seen, input [31:0] exp, input [8*10:1] what);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("Error %0s expected %0h seen %0h", what, exp, seen);
         end
      end
   endtask
   task stop_test;
      begin
         $display("Mismatches %0d in %0d checks", bad_count, samples_checked);
         if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask
   task host(input rd, input [5:0] a, input [7:0] d, output [7:0] q);
      begin
         @(posedge sys_clk);
         #1;
         cs_b = 1'b0;
         register_address_lines = a;
         host_wdata = d;
         rd_b = !rd;
         wr_b = rd;
         repeat (6) @(posedge sys_clk);
         #1;
         q = host_rdata;
         cs_b = 1'b1;
         rd_b = 1'b1;
         wr_b = 1'b1;
         repeat (6) @(posedge sys_clk);
         #1;
      end
   endtask
   task wr(input [5:0] a, input [7:0] d);
      reg [7:0] q;
      begin
         host(1'b0, a, d, q);
      end
   endtask
   task wait_bit(input integer i, input v, output integer t);
      integer n;
      begin
         n = 0;
         while (mon[i] !== v && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
         end
         if (n >= 20000) begin
            check(0, 1, "timeout");
            stop_test;
         end
         t = cyc;
      end
   endtask
   task rise(input integer i, output integer t);
      begin
         wait_bit(i, 1'b0, t);
         wait_bit(i, 1'b1, t);
      end
   endtask
   task t_host;
      reg [7:0] q;
      begin
         host(1'b1, `VTD_ADDR_LINE_TOTAL, 8'h00, q);
         check(q, 8'h00, "rd_total");
         host(1'b1, 6'h3f, 8'h00, q);
         check(q, 8'h00, "rd_unmap");
         wr(`VTD_ADDR_VCURS_WR, 8'h5a);
         wr(6'h19, 8'h21);
         host(1'b1, `VTD_ADDR_VCURS_RD, 8'h00, q);
         check(q, 8'h5a, "vcurs_lo");
         host(1'b1, 6'h39, 8'h00, q);
         check(q, 8'h21, "vcurs_hi");
         rd_b = 1'b0;
         light_pen_strobe_in = 1'b1;
         repeat (8) @(posedge sys_clk);
         #1;
         check(host_rdata_oe, 1'b0, "oe_no_cs");
         check(pen_latched, 1'b1, "pen");
         rd_b = 1'b1;
         light_pen_strobe_in = 1'b0;
         wr(`VTD_ADDR_PIN_SKEW, 8'h80);
         check(pin_function_sel, 2'h2, "pin_sel");
      end
   endtask
   task t_horiz;
      begin
         wr(`VTD_ADDR_LINE_TOTAL, 8'd20);
         wr(`VTD_ADDR_VIS_CHARS, 8'd9);
         wr(`VTD_ADDR_HS_DELAY, 8'd4);
         wr(`VTD_ADDR_HS_WIDTH, 8'd3);
         wr(`VTD_ADDR_VS_WIDTH, 8'd2);
         wr(`VTD_ADDR_VS_DELAY, 8'd3);
         wr(`VTD_ADDR_VIS_ROWS, 8'd1);
         wr(`VTD_ADDR_ROW_HEIGHT, 8'h01);
         wr(`VTD_ADDR_FRAME_LO, 8'd12);
         rise(0, ta);
         wait_bit(0, 1'b0, tb);
         check(tb - ta, 12, "hs_width");
         rise(0, tc);
         check(tc - ta, 80, "line_len");
         rise(2, tb);
         check((tb - tc) % 80, 16, "hs_to_vis");
         check(composite_blank_out, 1'b0, "blank_on");
         wait_bit(2, 1'b0, tc);
         check(tc - tb, 40, "vis_width");
         check(composite_blank_out, 1'b1, "blank_off");
         wr(`VTD_ADDR_PIN_SKEW, 8'h82);
         rise(2, ta);
         wait_bit(3, 1'b0, tb);
         check(tb - ta, 8, "blank_skew");
      end
   endtask
   task t_vert;
      begin
         rise(1, ta);
         wait_bit(1, 1'b0, tb);
         check(tb - ta, 160, "vs_width");
         rise(2, tc);
         check(tc - ta, 176, "vs_to_vis");
         repeat (4) rise(2, tc);
         check(tc - ta, 1136, "frame");
         wr(`VTD_ADDR_VCURS_WR, 8'h00);
         rise(2, ta);
         wait_bit(7, 1'b1, tb);
         check((tb - ta) % 80, 12, "cursor_out_pos");
      end
   endtask
   task t_dma(input [7:0] ctl, input integer n, input integer gap);
      integer w0;
      begin
         wr(`VTD_ADDR_DMA_CTRL, ctl);
         wr(`VTD_ADDR_START_CMD, 8'h00);
         rise(6, ta);
         w0 = words_at_ack;
         wait_bit(5, 1'b1, ta);
         wait_bit(5, 1'b0, tb);
         rise(4, tc);
         if (gap > 0) check(tc - tb >= gap && tc - tb <= gap + 12, 1'b1, "dma_gap");
         rise(6, ta);
         check(words_at_ack - w0, n, "burst_len");
      end
   endtask
   task t_stop;
      begin
         wr(`VTD_ADDR_DMA_CTRL, 8'h91);
         check({dma_request_out, display_memory_address_oe}, 2'h0, "dma_off");
         wr(`VTD_ADDR_DMA_CTRL, 8'h11);
         repeat (400) @(posedge sys_clk);
         #1;
         check(dma_request_out, 1'b0, "no_start");
      end
   endtask
   initial begin
      rst_b = 1'b0;
      cs_b = 1'b1;
      wr_b = 1'b1;
      rd_b = 1'b1;
      register_address_lines = 6'h00;
      host_wdata = 8'h00;
      light_pen_strobe_in = 1'b0;
      stall = 1'b1;
      bad_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge sys_clk);
      #1;
      rst_b = 1'b1;
      repeat (4) @(posedge sys_clk);
      t_host;
      t_horiz;
      t_vert;
      t_dma(8'h11, 8, 32);
      t_stop;
      stall = 1'b0;
      t_dma(8'h73, 10, 0);
      stop_test;
   end
endmodule // vtd_video_timing_test
